// File: acc_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control block.
// Assumes an 8-bit register port and a converter clock derived inside the block.
// Behaviour
// - With run-in-standby clear, stop in standby only after the running conversion ends.
// - Mode bit 0 converts positive input unsigned; 1 converts difference, signed.
// - Left-adjust bit 4 of the main control register left-aligns the result when the accumulation code is 0 (one sample).
// - Resolution code 0 selects 12 bits, code 1 selects 10 bits.
// - A 12-bit conversion lasts 13.5 converter cycles, a 10-bit one 11.5.
// - Free-running repeats conversions; software starts the first via the start bit.
// - Bit 0 of the main control register enables the converter.
// - Accumulation code 0 means one sample; codes 1 to 7 sum 2 to 128.
// - Divider code 0 to 0xD divides the peripheral clock by 2 up to 256.
// - Init delay of 0 to 256 converter cycles precedes the first sample after enable.
// - Init delay also applies when waking from deep sleep for a measurement.
// - Sample spacing inserts 0 to 15 converter cycles between consecutive samples.
// - Window mode sets the match flag below, above, inside or outside the thresholds.
// - Start bit reads one while converting, clears itself; writing zero does nothing.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

`define ACC_OFS_MAIN      4'h0
`define ACC_OFS_ACCUM     4'h1
`define ACC_OFS_CLOCK_DIVIDER_SELECT     4'h2
`define ACC_OFS_DELAY     4'h3
`define ACC_OFS_WINDOW    4'h4
`define ACC_OFS_COMMAND   4'h5
`define ACC_OFS_STATUS    4'h6
`define ACC_OFS_MASK      4'h7
`define ACC_OFS_RES_LO    4'h8
`define ACC_OFS_RES_HI    4'h9
`define ACC_OFS_WLO_LO    4'hA
`define ACC_OFS_WLO_HI    4'hB
`define ACC_OFS_WHI_LO    4'hC
`define ACC_OFS_WHI_HI    4'hD

`define ACC_BIT_ENABLE    0
`define ACC_BIT_FREE_RUNNING_BIT   1
`define ACC_POS_RESOLUTION_SELECT    2
`define ACC_BIT_LEFT_ADJUST_BIT   4
`define ACC_BIT_CONVERSION_MODE_BIT  5
`define ACC_BIT_RUN_IN_STANDBY_BIT  7
`define ACC_POS_INIT_DELAY   5
`define ACC_BIT_START     0
`define ACC_BIT_RESRDY    0
`define ACC_BIT_WINMATCH  1

`define ACC_RESET_BYTE    8'h00
`define ACC_RESET_WORD    16'h0000

`define ACC_CONV12_HALF   5'h1B
`define ACC_CONV10_HALF   5'h17

`endif

// File: acc_pkg.sv
// Types shared by the converter control block.
// Assumes acc_map.svh supplies the numeric constants.
package acc_pkg;

	typedef struct packed {
		logic       run_in_standby_bit;
		logic       conversion_mode_bit;
		logic       left_adjust_bit;
		logic [1:0] resolution_select;
		logic       free_running_bit;
		logic       enable_bit;
		logic [2:0] accumulation_count;
		logic [3:0] clock_divider_select;
		logic [2:0] init_delay;
		logic [3:0] sample_spacing_delay;
		logic [2:0] window_compare_mode;
	} acc_cfg_t;

	typedef enum logic [2:0] {
		WIN_NONE,
		WIN_BELOW,
		WIN_ABOVE,
		WIN_INSIDE,
		WIN_OUTSIDE
	} acc_win_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INIT,
		ST_CONVERT,
		ST_SPACING
	} acc_state_t;

endpackage : acc_pkg

// File: acc_clkdiv.sv
// Prescaler that derives the converter clock from the peripheral clock.
// Assumes the select code comes from a register on the same clock.
`timescale 1ns/1ps
module acc_clkdiv
	import acc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [3:0] sel_in,
	output logic            conv_clk_out,
	output logic            half_tick_out,
	output logic            rise_tick_out
);

	logic [6:0] cnt;
	wire  [6:0] half_period;
	wire        wrap;

	function automatic logic [6:0] half_of(input logic [3:0] code);
		case (code)
			4'h0: half_of = 7'h01;
			4'h1: half_of = 7'h02;
			4'h2: half_of = 7'h04;
			4'h3: half_of = 7'h06;
			4'h4: half_of = 7'h08;
			4'h5: half_of = 7'h0A;
			4'h6: half_of = 7'h0C;
			4'h7: half_of = 7'h0E;
			4'h8: half_of = 7'h10;
			4'h9: half_of = 7'h18;
			4'hA: half_of = 7'h20;
			4'hB: half_of = 7'h30;
			4'hC: half_of = 7'h40;
			// A half period of 128 wraps to zero, so the terminal count below becomes 127.
			default: half_of = 7'h00;
		endcase
	endfunction : half_of

	assign half_period   = half_of(sel_in);
	assign wrap          = (cnt >= half_period - 7'h01);
	assign half_tick_out = wrap;
	assign rise_tick_out = wrap & ~conv_clk_out;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt          <= 7'h00;
			conv_clk_out <= 1'b0;
		end else if (wrap) begin
			cnt          <= 7'h00;
			conv_clk_out <= ~conv_clk_out;
		end else begin
			cnt <= cnt + 7'h01;
		end
	end

endmodule : acc_clkdiv

// File: acc_accum.sv
// Sample accumulator, result alignment and window comparator.
// Assumes add and finish are single-cycle pulses from the sequencer, finish after the last add.
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_accum
	import acc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire acc_cfg_t    cfg_in,
	input  wire logic        clear_in,
	input  wire logic        add_in,
	input  wire logic [11:0] sample_in,
	input  wire logic        finish_in,
	input  wire logic [15:0] win_low_in,
	input  wire logic [15:0] win_high_in,
	output logic [15:0]      result_out,
	output logic             win_hit_out
);

	logic [15:0] sum;
	wire  [15:0] ext_sample;
	wire  [15:0] next_result;
	wire         below;
	wire         above;
	wire         hit;
	wire         res10;

	assign res10 = (cfg_in.resolution_select == 2'h1);
	assign ext_sample = res10 ?
		(cfg_in.conversion_mode_bit ? {{6{sample_in[9]}}, sample_in[9:0]} : {6'h00, sample_in[9:0]}) :
		(cfg_in.conversion_mode_bit ? {{4{sample_in[11]}}, sample_in} : {4'h0, sample_in});

	assign next_result = (cfg_in.left_adjust_bit && cfg_in.accumulation_count == 3'h0) ?
		(res10 ? {sum[9:0], 6'h00} : {sum[11:0], 4'h0}) : sum;

	assign below = cfg_in.conversion_mode_bit ? ($signed(next_result) < $signed(win_low_in)) :
		(next_result < win_low_in);
	assign above = cfg_in.conversion_mode_bit ? ($signed(next_result) > $signed(win_high_in)) :
		(next_result > win_high_in);

	assign hit = (cfg_in.window_compare_mode == WIN_BELOW)   ? below :
		(cfg_in.window_compare_mode == WIN_ABOVE)   ? above :
		(cfg_in.window_compare_mode == WIN_INSIDE)  ? (~below & ~above) :
		(cfg_in.window_compare_mode == WIN_OUTSIDE) ? (below | above) : 1'b0;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sum         <= `ACC_RESET_WORD;
			result_out  <= `ACC_RESET_WORD;
			win_hit_out <= 1'b0;
		end else begin
			win_hit_out <= finish_in & hit;
			if (finish_in) begin
				result_out <= next_result;
			end
			if (clear_in || finish_in) begin
				sum <= `ACC_RESET_WORD;
			end else if (add_in) begin
				sum <= sum + ext_sample;
			end
		end
	end

endmodule : acc_accum

// File: acc_top.sv
// Converter control and configuration block: registers, sequencer, prescaler and accumulator.
// Assumes the analog core returns stable data by the end of each conversion and sleep inputs are on this clock.
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_top
	import acc_pkg::*;
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic [3:0]  ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [7:0]  RDATA_OUT,
	input  wire logic        STANDBY_IN,
	input  wire logic        DEEP_SLEEP_IN,
	input  wire logic        INT_REF_IN,
	input  wire logic [11:0] CORE_DATA_IN,
	output logic             CONV_CLK_OUT,
	output logic             CORE_SAMPLE_OUT,
	output logic             CORE_DIFFERENTIAL_MODE_OUT,
	output logic             CORE_RES10_OUT,
	output logic             CORE_ACTIVE_OUT,
	output logic             IRQ_OUT
);

	logic [7:0]  converter_control_main;
	logic [7:0]  accumulation_control;
	logic [7:0]  clock_prescale_control;
	logic [7:0]  delay_control;
	logic [7:0]  window_compare_control;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [15:0] win_low;
	logic [15:0] win_high;
	logic [11:0] data_meta;
	logic [11:0] data_sync;
	acc_state_t  state;
	acc_state_t  next_state;
	logic        start_pend;
	logic        init_pend;
	logic        finish_pend;
	logic [4:0]  half_cnt;
	logic [8:0]  dly_cnt;
	logic [7:0]  sample_idx;
	logic        enable_q;
	logic        int_ref_q;
	logic        deep_q;
	logic        stop_q;
	logic [7:0]  next_rdata;

	acc_cfg_t    cfg;
	wire         half_tick;
	wire         rise_tick;
	wire  [15:0] result;
	wire         win_hit;
	wire         sel_wr;
	wire         stand_stop;
	wire         busy;
	wire  [4:0]  conv_len;
	wire  [8:0]  init_len;
	wire  [7:0]  needed;
	wire         conv_end;
	wire         last_sample;
	wire         can_start;
	wire         init_exit;
	wire         space_exit;
	wire         seq_clear;
	wire  [1:0]  ev;
	wire         wake_event;

	function automatic logic [8:0] init_cycles(input logic [2:0] code);
		case (code)
			3'h0: init_cycles = 9'h000;
			3'h1: init_cycles = 9'h010;
			3'h2: init_cycles = 9'h020;
			3'h3: init_cycles = 9'h040;
			3'h4: init_cycles = 9'h080;
			default: init_cycles = 9'h100;
		endcase
	endfunction : init_cycles

	assign cfg.run_in_standby_bit   = converter_control_main[`ACC_BIT_RUN_IN_STANDBY_BIT];
	assign cfg.conversion_mode_bit  = converter_control_main[`ACC_BIT_CONVERSION_MODE_BIT];
	assign cfg.left_adjust_bit      = converter_control_main[`ACC_BIT_LEFT_ADJUST_BIT];
	assign cfg.resolution_select    = converter_control_main[`ACC_POS_RESOLUTION_SELECT +: 2];
	assign cfg.free_running_bit     = converter_control_main[`ACC_BIT_FREE_RUNNING_BIT];
	assign cfg.enable_bit           = converter_control_main[`ACC_BIT_ENABLE];
	assign cfg.accumulation_count   = accumulation_control[2:0];
	assign cfg.clock_divider_select = clock_prescale_control[3:0];
	assign cfg.init_delay           = delay_control[`ACC_POS_INIT_DELAY +: 3];
	assign cfg.sample_spacing_delay = delay_control[3:0];
	assign cfg.window_compare_mode  = window_compare_control[2:0];

	acc_clkdiv u_clkdiv (
		.clk_in        (REF_CLK_IN),
		.rst_n_in      (RST_N_IN),
		.sel_in        (cfg.clock_divider_select),
		.conv_clk_out  (CONV_CLK_OUT),
		.half_tick_out (half_tick),
		.rise_tick_out (rise_tick)
	);

	acc_accum u_accum (
		.clk_in      (REF_CLK_IN),
		.rst_n_in    (RST_N_IN),
		.cfg_in      (cfg),
		.clear_in    (seq_clear),
		.add_in      (conv_end),
		.sample_in   (data_sync),
		.finish_in   (finish_pend),
		.win_low_in  (win_low),
		.win_high_in (win_high),
		.result_out  (result),
		.win_hit_out (win_hit)
	);

	assign sel_wr      = WR_IN;
	assign stand_stop  = STANDBY_IN & ~cfg.run_in_standby_bit;
	assign busy        = start_pend | (state != ST_IDLE) | finish_pend;
	assign conv_len    = (cfg.resolution_select == 2'h1) ? `ACC_CONV10_HALF : `ACC_CONV12_HALF;
	assign init_len    = init_cycles(cfg.init_delay);
	assign needed      = 8'h01 << cfg.accumulation_count;
	assign conv_end    = (state == ST_CONVERT) & half_tick & (half_cnt == conv_len - 5'h01);
	assign last_sample = (sample_idx == needed - 8'h01);
	assign can_start   = cfg.enable_bit & start_pend & ~stand_stop;
	assign init_exit   = (state == ST_INIT) & rise_tick & (dly_cnt >= init_len - 9'h001);
	assign space_exit  = (state == ST_SPACING) & rise_tick &
		(dly_cnt >= {5'h00, cfg.sample_spacing_delay} - 9'h001);
	assign seq_clear   = (state == ST_IDLE) & can_start;
	assign wake_event  = (enable_q == 1'b0 && cfg.enable_bit) || (INT_REF_IN && !int_ref_q) ||
		(deep_q && !DEEP_SLEEP_IN) || (stop_q && !stand_stop);
	assign ev          = {win_hit, finish_pend};

	assign CORE_SAMPLE_OUT = (state == ST_CONVERT);
	assign CORE_ACTIVE_OUT = cfg.enable_bit & ~(stand_stop & (state == ST_IDLE));
	assign IRQ_OUT         = |(status & mask);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (can_start) begin
					next_state = (init_pend && init_len != 9'h000) ? ST_INIT : ST_CONVERT;
				end
			end
			ST_INIT: begin
				if (init_exit) begin
					next_state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (conv_end) begin
					if (last_sample && (!cfg.free_running_bit || stand_stop)) begin
						next_state = ST_IDLE;
					end else if (cfg.sample_spacing_delay != 4'h0) begin
						next_state = ST_SPACING;
					end else begin
						next_state = ST_CONVERT;
					end
				end
			end
			ST_SPACING: begin
				if (space_exit) begin
					next_state = ST_CONVERT;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (!cfg.enable_bit) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			half_cnt   <= 5'h00;
			dly_cnt    <= 9'h000;
			sample_idx <= 8'h00;
		end else begin
			if (state != next_state || state == ST_IDLE) begin
				half_cnt <= 5'h00;
				dly_cnt  <= 9'h000;
			end else if (conv_end) begin
				half_cnt <= 5'h00;
			end else begin
				half_cnt <= half_cnt + {4'h0, half_tick & (state == ST_CONVERT)};
				dly_cnt  <= dly_cnt + {8'h00, rise_tick & (state != ST_CONVERT)};
			end
			if (next_state == ST_IDLE || (conv_end && last_sample)) begin
				sample_idx <= 8'h00;
			end else if (conv_end) begin
				sample_idx <= sample_idx + 8'h01;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			start_pend  <= 1'b0;
			init_pend   <= 1'b0;
			finish_pend <= 1'b0;
			enable_q    <= 1'b0;
			int_ref_q   <= 1'b0;
			deep_q      <= 1'b0;
			stop_q      <= 1'b0;
		end else begin
			enable_q    <= cfg.enable_bit;
			int_ref_q   <= INT_REF_IN;
			deep_q      <= DEEP_SLEEP_IN;
			stop_q      <= stand_stop;
			finish_pend <= conv_end & last_sample;
			if (!cfg.enable_bit) begin
				start_pend <= 1'b0;
			end else if (sel_wr && ADDR_IN == `ACC_OFS_COMMAND && WDATA_IN[`ACC_BIT_START]) begin
				start_pend <= 1'b1;
			end else if (conv_end && last_sample && cfg.free_running_bit && stand_stop) begin
				start_pend <= 1'b1;
			end else if (seq_clear) begin
				start_pend <= 1'b0;
			end
			if (wake_event) begin
				init_pend <= 1'b1;
			end else if (state == ST_INIT || seq_clear) begin
				init_pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			data_meta <= 12'h000;
			data_sync <= 12'h000;
		end else begin
			data_meta <= CORE_DATA_IN;
			data_sync <= data_meta;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			CORE_DIFFERENTIAL_MODE_OUT  <= 1'b0;
			CORE_RES10_OUT <= 1'b0;
		end else if (state == ST_IDLE) begin
			CORE_DIFFERENTIAL_MODE_OUT  <= cfg.conversion_mode_bit;
			CORE_RES10_OUT <= (cfg.resolution_select == 2'h1);
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			converter_control_main <= `ACC_RESET_BYTE;
			accumulation_control   <= `ACC_RESET_BYTE;
			clock_prescale_control <= `ACC_RESET_BYTE;
			delay_control          <= `ACC_RESET_BYTE;
			window_compare_control <= `ACC_RESET_BYTE;
			mask                   <= 2'h0;
			win_low                <= `ACC_RESET_WORD;
			win_high               <= `ACC_RESET_WORD;
		end else if (sel_wr) begin
			case (ADDR_IN)
				`ACC_OFS_MAIN:   converter_control_main <= WDATA_IN & 8'hBF;
				`ACC_OFS_ACCUM:  accumulation_control   <= WDATA_IN & 8'h07;
				`ACC_OFS_CLOCK_DIVIDER_SELECT:  clock_prescale_control <= WDATA_IN & 8'h0F;
				`ACC_OFS_DELAY:  delay_control          <= WDATA_IN & 8'hEF;
				`ACC_OFS_WINDOW: window_compare_control <= WDATA_IN & 8'h07;
				`ACC_OFS_MASK:   mask                   <= WDATA_IN[1:0];
				`ACC_OFS_WLO_LO: win_low[7:0]           <= WDATA_IN;
				`ACC_OFS_WLO_HI: win_low[15:8]          <= WDATA_IN;
				`ACC_OFS_WHI_LO: win_high[7:0]          <= WDATA_IN;
				`ACC_OFS_WHI_HI: win_high[15:8]         <= WDATA_IN;
				default: ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_status
			always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					status[gi] <= 1'b0;
				end else if (ev[gi]) begin
					status[gi] <= 1'b1;
				end else if (sel_wr && ADDR_IN == `ACC_OFS_STATUS && WDATA_IN[gi]) begin
					status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		next_rdata = 8'h00;
		if (RD_IN) begin
			case (ADDR_IN)
				`ACC_OFS_MAIN:    next_rdata = converter_control_main;
				`ACC_OFS_ACCUM:   next_rdata = accumulation_control;
				`ACC_OFS_CLOCK_DIVIDER_SELECT:   next_rdata = clock_prescale_control;
				`ACC_OFS_DELAY:   next_rdata = delay_control;
				`ACC_OFS_WINDOW:  next_rdata = window_compare_control;
				`ACC_OFS_COMMAND: next_rdata = {7'h00, busy};
				`ACC_OFS_STATUS:  next_rdata = {6'h00, status};
				`ACC_OFS_MASK:    next_rdata = {6'h00, mask};
				`ACC_OFS_RES_LO:  next_rdata = result[7:0];
				`ACC_OFS_RES_HI:  next_rdata = result[15:8];
				`ACC_OFS_WLO_LO:  next_rdata = win_low[7:0];
				`ACC_OFS_WLO_HI:  next_rdata = win_low[15:8];
				`ACC_OFS_WHI_LO:  next_rdata = win_high[7:0];
				`ACC_OFS_WHI_HI:  next_rdata = win_high[15:8];
				default:          next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			RDATA_OUT <= 8'h00;
		end else begin
			RDATA_OUT <= next_rdata;
		end
	end

	logic [4:0] meas_half;
	logic [8:0] meas_rise;

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			meas_half <= 5'h00;
			meas_rise <= 9'h000;
		end else begin
			meas_half <= (state != ST_CONVERT || conv_end) ? 5'h00 : meas_half + {4'h0, half_tick};
			meas_rise <= (state == ST_IDLE || state == ST_CONVERT || init_exit || space_exit) ? 9'h000 :
				meas_rise + {8'h00, rise_tick};
		end
	end

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	AST_STANDBY_HOLD: assert property ((state == ST_IDLE) && stand_stop |=> state == ST_IDLE)
		else $error("Converter left idle while stopped in standby.");
	AST_STANDBY_FINISH: assert property ((state == ST_CONVERT) && stand_stop && !conv_end && cfg.enable_bit
		|=> state == ST_CONVERT)
		else $error("Conversion abandoned on standby.");
	AST_DIFFERENTIAL_MODE_MODE: assert property ((state == ST_IDLE) ##1 (state == ST_CONVERT) |->
		CORE_DIFFERENTIAL_MODE_OUT == $past(cfg.conversion_mode_bit))
		else $error("Core mode does not follow the mode bit.");
	AST_CONV_LENGTH: assert property (conv_end |-> meas_half == ((cfg.resolution_select == 2'h1) ? 5'h16 : 5'h1A))
		else $error("Conversion length wrong.");
	AST_FREE_RUN: assert property (conv_end && last_sample && cfg.free_running_bit && !stand_stop &&
		cfg.enable_bit && cfg.sample_spacing_delay == 4'h0 |=> state == ST_CONVERT)
		else $error("Free-running did not restart.");
	AST_DISABLE: assert property (!cfg.enable_bit |=> state == ST_IDLE && !start_pend)
		else $error("Disabled converter still active.");
	AST_INIT_LEN: assert property (init_exit |-> meas_rise == init_len - 9'h001)
		else $error("Init delay length wrong.");
	AST_SPACING_LEN: assert property (space_exit |-> meas_rise[3:0] == cfg.sample_spacing_delay - 4'h1)
		else $error("Sample spacing length wrong.");
	AST_START_BUSY: assert property (WR_IN && ADDR_IN == `ACC_OFS_COMMAND && WDATA_IN[0] && cfg.enable_bit
		##[1:4] RD_IN && ADDR_IN == `ACC_OFS_COMMAND && cfg.enable_bit |=> RDATA_OUT[0])
		else $error("Start bit does not read busy.");
	AST_RESRDY_SET: assert property (finish_pend |=> status[`ACC_BIT_RESRDY])
		else $error("Result ready not set.");

	COV_ACCUM: cover property (finish_pend && cfg.accumulation_count == 3'h7);
	COV_FREE_SPACING: cover property (space_exit && cfg.free_running_bit);
	COV_WIN_HIT: cover property (win_hit && IRQ_OUT == 1'b0 ##1 IRQ_OUT);
	COV_INIT: cover property (init_exit && cfg.init_delay == 3'h5);

endmodule : acc_top

// File: acc_core_model.sv
// Stand-in for the analog conversion core behind the converter control block.
// Assumes the block reads the code near the end of each conversion.
`timescale 1ns/1ps
module acc_core_model (
	input  wire logic        clk_in,
	input  wire logic        sample_in,
	input  wire logic [11:0] value_in,
	output logic      [11:0] data_out
);
	initial data_out = 12'hA5A;
	// Outside a conversion the lines change every cycle.
	always @(posedge clk_in) begin
		if (sample_in)
			data_out <= value_in;
		else
			data_out <= ~data_out;
	end
endmodule : acc_core_model

// File: tb.sv
// Self-checking bench for the converter control block.
// Assumes acc_core_model answers on the core side.
`timescale 1ns/1ps
module tb;
	logic        clk, rst_n, wr, rd, sby, deep, iref, pv;
	logic [3:0]  addr;
	logic [7:0]  wd;
	logic [7:0]  rdat;
	logic [11:0] core, val;
	logic        cclk, samp, differential_mode, r10, act, irq;
	int          failures, n_checks, hi, first, last, n, f0, s0;

	acc_top dut_u (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr),
		.RD_IN(rd), .RDATA_OUT(rdat), .STANDBY_IN(sby), .DEEP_SLEEP_IN(deep), .INT_REF_IN(iref),
		.CORE_DATA_IN(core), .CONV_CLK_OUT(cclk), .CORE_SAMPLE_OUT(samp), .CORE_DIFFERENTIAL_MODE_OUT(differential_mode),
		.CORE_RES10_OUT(r10), .CORE_ACTIVE_OUT(act), .IRQ_OUT(irq));
	acc_core_model core_u (.clk_in(clk), .sample_in(samp), .value_in(val), .data_out(core));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task wreg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wreg

	task rchk(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdat});
		@(posedge clk);
	endtask : rchk

	task meas(input int cyc);
		hi = 0;
		n = 0;
		first = -1;
		pv = 1'b0;
		for (int i = 0; i < cyc; i++) begin
			if (samp)
				hi++;
			if (samp && !pv) begin
				n++;
				last = i;
				if (first < 0)
					first = i;
			end
			pv = samp;
			@(posedge clk);
			#1;
		end
	endtask : meas

	task go(input int cyc);
		wreg(4'h5, 8'h01);
		meas(cyc);
	endtask : go

	task wait_c(input logic v);
		for (hi = 0; hi < 600 && cclk !== v; hi++) begin
			@(posedge clk);
			#1;
		end
		if (cclk !== v) begin
			failures++;
			$display("BAD timeout expected %h seen %h", v, cclk);
			report_and_stop;
		end
	endtask : wait_c

	task t_regs;
		logic [7:0] m [5] = '{8'hBF, 8'h07, 8'h0F, 8'hEF, 8'h07};
		for (int a = 0; a < 5; a++) begin
			rchk(4'(a), 8'h00);
			wreg(4'(a), 8'hFF);
			rchk(4'(a), m[a]);
		end
		wreg(4'hE, 8'hFF);
		rchk(4'hE, 8'h00);
		for (int a = 0; a < 5; a++)
			wreg(4'(a), 8'h00);
	endtask : t_regs

	task t_conv;
		int h12;
		val = 12'h5A3;
		wreg(4'h2, 8'h01);
		wreg(4'h0, 8'h01);
		go(100);
		h12 = hi;
		chk("len12", 1, h12 >= 53 && h12 <= 54);
		rchk(4'h8, 8'hA3);
		rchk(4'h9, 8'h05);
		rchk(4'h6, 8'h01);
		chk("irq", 0, irq);
		wreg(4'h7, 8'h01);
		chk("irq", 1, irq);
		wreg(4'h6, 8'h01);
		chk("irq", 0, irq);
		wreg(4'h0, 8'h05);
		chk("res10", 1, r10);
		go(100);
		chk("len10", 1, hi >= 45 && hi <= 46);
		wreg(4'h5, 8'h01);
		wreg(4'h5, 8'h00);
		rchk(4'h5, 8'h01);
		meas(100);
		rchk(4'h5, 8'h00);
		wreg(4'h7, 8'h00);
	endtask : t_conv

	task t_acc;
		wreg(4'h2, 8'h00);
		wreg(4'h0, 8'h01);
		wreg(4'h1, 8'h02);
		val = 12'h123;
		for (int s = 0; s < 16; s += 15) begin
			wreg(4'h3, 8'(s));
			go(400);
			if (s == 0)
				chk("busy", 108, 16'(hi));
			else
				chk("samples", 4, 16'(n));
			rchk(4'h8, 8'h8C);
			rchk(4'h9, 8'h04);
		end
		s0 = last - first - 81;
		chk("spacing", 1, s0 >= 87 && s0 <= 93);
		wreg(4'h1, 8'h00);
		wreg(4'h3, 8'h00);
	endtask : t_acc

	task t_adj;
		wreg(4'h0, 8'h11);
		go(100);
		f0 = first;
		rchk(4'h8, 8'h30);
		rchk(4'h9, 8'h12);
		wreg(4'h0, 8'h00);
		wreg(4'h3, 8'h20);
		wreg(4'h0, 8'h01);
		go(150);
		chk("init", 1, first - f0 >= 31 && first - f0 <= 34);
		deep <= 1'b1;
		@(posedge clk);
		deep <= 1'b0;
		go(150);
		chk("wake", 1, first - f0 >= 31 && first - f0 <= 34);
		iref <= 1'b1;
		go(150);
		chk("iref", 1, first - f0 >= 31 && first - f0 <= 34);
		iref <= 1'b0;
		wreg(4'h3, 8'h00);
	endtask : t_adj

	task t_modes;
		wreg(4'h0, 8'h03);
		go(200);
		chk("free_running_bit", 200, 16'(hi));
		wreg(4'h3, 8'h01);
		meas(200);
		chk("spaced", 1, n >= 6);
		rchk(4'h5, 8'h01);
		wreg(4'h0, 8'h00);
		chk("stop", 0, samp | act);
		go(60);
		chk("refused", 0, 16'(n));
		wreg(4'h0, 8'h01);
		wreg(4'h5, 8'h01);
		@(posedge clk);
		sby <= 1'b1;
		#1;
		meas(60);
		chk("finish", 1, hi >= 23 && hi <= 27);
		chk("asleep", 0, act);
		wreg(4'h0, 8'h81);
		chk("awake", 1, act);
		sby <= 1'b0;
		wreg(4'h0, 8'h21);
		chk("differential_mode", 1, differential_mode);
		val = 12'hFFE;
		go(60);
		rchk(4'h9, 8'hFF);
		rchk(4'h8, 8'hFE);
		val = 12'h123;
		wreg(4'h6, 8'h03);
		wreg(4'hA, 8'h00);
		wreg(4'hB, 8'h02);
		wreg(4'h4, 8'h01);
		wreg(4'h0, 8'h01);
		go(60);
		rchk(4'h6, 8'h03);
	endtask : t_modes

	task t_div;
		int dv [14] = '{2, 4, 8, 12, 16, 20, 24, 28, 32, 48, 64, 96, 128, 256};
		for (int c = 0; c < 14; c++) begin
			wreg(4'h2, 8'(c));
			wait_c(1'b0);
			wait_c(1'b1);
			wait_c(1'b0);
			chk("half", 16'(dv[c] / 2), 16'(hi));
		end
	endtask : t_div

	task report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	initial begin
		failures = 0;
		n_checks = 0;
		{rst_n, wr, rd, sby, deep, iref, addr, wd, val} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_conv;
		t_acc;
		t_adj;
		t_modes;
		t_div;
		report_and_stop;
	end
endmodule : tb
